// >>> include/serial_front_pkg.sv
// constants and types shared by the serial port front end
// assumes a 100 MHz core clock; the host serial clock is a separate domain
package serial_front_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned UART_BAUD_MAX = 38_400;
   localparam int unsigned SYNC_BPS_MAX = 1_000_000;
   // one bit time at the highest uart rate, rounded down to whole cycles
   localparam int unsigned UART_BIT_CYC = CLK_HZ / UART_BAUD_MAX;
   localparam logic [15:0] UART_BIT_CNT = 16'(UART_BIT_CYC - 1);
   localparam logic [15:0] UART_HALF_CNT = 16'(UART_BIT_CYC / 2 - 1);
   localparam logic [3:0] UART_LAST_DATA = 4'h7;
   localparam logic [2:0] SYNC_LAST_BIT = 3'h7;
   localparam logic [2:0] SYNC_FIRST_BIT = 3'h0;
   localparam int unsigned IRQ_PULSE_NS = 1000;
   localparam int unsigned IRQ_PULSE_CYC = IRQ_PULSE_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam logic [7:0] IRQ_PULSE_CNT = 8'(IRQ_PULSE_CYC - 1);
   // arbitrary code sent on the transmit line as interrupt notification
   localparam logic [7:0] IRQ_NOTIFY_CHAR = 8'hA5;
   localparam logic SEL_UART = 1'b0;
   localparam logic SEL_SYNC = 1'b1;
   // positions in the core-clock synchroniser vector
   localparam int unsigned MS_SEL = 0;
   localparam int unsigned MS_TEST = 1;
   localparam int unsigned MS_RXD = 2;
   localparam int unsigned MS_RXTGL = 3;
   localparam int unsigned MS_ACK = 4;
   localparam int unsigned MS_W = 5;
   // positions in the serial-clock synchroniser vector
   localparam int unsigned LS_SEL = 0;
   localparam int unsigned LS_RSTN = 1;
   localparam int unsigned LS_REQ = 2;
   localparam int unsigned LS_W = 3;
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} frame_state_e;
endpackage

// >>> hw/uart_framer.sv
// uart character transmitter and receiver on the core clock
// assumes rx_line is already synchronised; idle line level is high
`timescale 1ns/10ps
module uart_framer (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic rx_line,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic tx_line,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_error
);
   serial_front_pkg::frame_state_e tx_st_q;
   serial_front_pkg::frame_state_e rx_st_q;
   logic [15:0] tx_cnt_q;
   logic [15:0] rx_cnt_q;
   logic [3:0] tx_bit_q;
   logic [3:0] rx_bit_q;
   logic [7:0] tx_shift_q;
   logic [7:0] rx_shift_q;
   logic tx_par_q;
   logic rx_par_q;
   logic tx_line_q;
   logic rx_prev_q;
   logic rx_valid_q;
   logic [7:0] rx_data_q;
   logic rx_error_q;
   wire tx_tick = (tx_cnt_q == 16'h0000);
   wire rx_tick = (rx_cnt_q == 16'h0000);
   wire tx_take = tx_valid & tx_ready;
   wire rx_fall = enable & rx_prev_q & ~rx_line;

   assign tx_ready = enable & (tx_st_q == serial_front_pkg::ST_IDLE);
   assign tx_line = tx_line_q;
   assign rx_valid = rx_valid_q;
   assign rx_data = rx_data_q;
   assign rx_error = rx_error_q;

   // start, eight data bits lsb first, even parity, stop
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tx_st_q <= serial_front_pkg::ST_IDLE;
         tx_cnt_q <= 16'h0000;
         tx_bit_q <= 4'h0;
         tx_shift_q <= 8'h00;
         tx_par_q <= 1'b0;
         tx_line_q <= 1'b1;
      end else if (tx_st_q == serial_front_pkg::ST_IDLE) begin
         if (tx_take) begin
            tx_shift_q <= tx_data;
            tx_par_q <= ^tx_data;
            tx_line_q <= 1'b0;
            tx_cnt_q <= serial_front_pkg::UART_BIT_CNT;
            tx_st_q <= serial_front_pkg::ST_START;
         end
      end else if (!tx_tick) begin
         tx_cnt_q <= tx_cnt_q - 16'h0001;
      end else begin
         tx_cnt_q <= serial_front_pkg::UART_BIT_CNT;
         case (tx_st_q)
            serial_front_pkg::ST_START: begin
               tx_line_q <= tx_shift_q[0];
               tx_shift_q <= {1'b0, tx_shift_q[7:1]};
               tx_bit_q <= 4'h0;
               tx_st_q <= serial_front_pkg::ST_DATA;
            end
            serial_front_pkg::ST_DATA: begin
               if (tx_bit_q == serial_front_pkg::UART_LAST_DATA) begin
                  tx_line_q <= tx_par_q;
                  tx_st_q <= serial_front_pkg::ST_PARITY;
               end else begin
                  tx_line_q <= tx_shift_q[0];
                  tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                  tx_bit_q <= tx_bit_q + 4'h1;
               end
            end
            serial_front_pkg::ST_PARITY: begin
               tx_line_q <= 1'b1;
               tx_st_q <= serial_front_pkg::ST_STOP;
            end
            default: tx_st_q <= serial_front_pkg::ST_IDLE;
         endcase
      end
   end

   // samples mid-bit; parity or stop fault raises rx_error
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_st_q <= serial_front_pkg::ST_IDLE;
         rx_cnt_q <= 16'h0000;
         rx_bit_q <= 4'h0;
         rx_shift_q <= 8'h00;
         rx_par_q <= 1'b0;
         rx_prev_q <= 1'b1;
         rx_valid_q <= 1'b0;
         rx_data_q <= 8'h00;
         rx_error_q <= 1'b0;
      end else begin
         rx_prev_q <= rx_line;
         rx_valid_q <= 1'b0;
         if (rx_st_q == serial_front_pkg::ST_IDLE) begin
            if (rx_fall) begin
               rx_cnt_q <= serial_front_pkg::UART_HALF_CNT;
               rx_st_q <= serial_front_pkg::ST_START;
            end
         end else if (!rx_tick) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
         end else begin
            rx_cnt_q <= serial_front_pkg::UART_BIT_CNT;
            case (rx_st_q)
               serial_front_pkg::ST_START: begin
                  rx_bit_q <= 4'h0;
                  rx_st_q <= rx_line ? serial_front_pkg::ST_IDLE : serial_front_pkg::ST_DATA;
               end
               serial_front_pkg::ST_DATA: begin
                  rx_shift_q <= {rx_line, rx_shift_q[7:1]};
                  rx_bit_q <= rx_bit_q + 4'h1;
                  if (rx_bit_q == serial_front_pkg::UART_LAST_DATA) begin
                     rx_st_q <= serial_front_pkg::ST_PARITY;
                  end
               end
               serial_front_pkg::ST_PARITY: begin
                  rx_par_q <= rx_line;
                  rx_st_q <= serial_front_pkg::ST_STOP;
               end
               default: begin
                  rx_valid_q <= 1'b1;
                  rx_data_q <= rx_shift_q;
                  rx_error_q <= (^{rx_shift_q, rx_par_q}) | ~rx_line;
                  rx_st_q <= serial_front_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // uart_framer

// >>> hw/host_serial_port_front_end.sv
// host serial port front end: uart or clock-synchronous port on shared pins
// assumes the core side runs on mclk; rx_sck_pin is the host serial clock in
// synchronous mode and carries receive data in uart mode
//
// How it works
// - select low picks uart, high picks clock-synchronous port
// - receive pin is uart data, or serial clock from host in synchronous mode
// - transmit pins are uart output, or the shared bidirectional data line
// - transmit and interrupt pins only pull low or release; host pulls up
// - tunnel command arrival gives a low pulse on the interrupt pins
// - uart at most 38.4 kbps, synchronous clock at most 1 Mbps
// - in serial mode host is master; this port only answers
// - in tunnel mode reader/writer is master, commands relayed to host
// - in rf mode reader/writer is master; device answers as slave
// - uart character is start, eight data lsb first, even parity, stop
// - in uart mode the interrupt is also sent as a notify character
`timescale 1ns/10ps
module host_serial_port_front_end (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sel,
   input wire logic test_mode,
   input wire logic rx_sck_pin,
   input wire logic serial_out_low_volt_in,
   output logic serial_out_low_volt_out,
   output logic serial_out_low_volt_oe_n,
   input wire logic serial_out_high_volt_in,
   output logic serial_out_high_volt_out,
   output logic serial_out_high_volt_oe_n,
   output logic host_interrupt_low_volt_out,
   output logic host_interrupt_low_volt_oe_n,
   output logic host_interrupt_high_volt_out,
   output logic host_interrupt_high_volt_oe_n,
   input wire logic tunnel_cmd_event,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_error,
   output logic sync_mode
);
   // core clock side
   logic [serial_front_pkg::MS_W-1:0] msync_a_q;
   logic [serial_front_pkg::MS_W-1:0] msync_b_q;
   logic rx_tgl_seen_q;
   logic tx_req_q;
   logic [7:0] tx_hold_q;
   logic irq_pend_q;
   logic irq_act_q;
   logic [7:0] irq_cnt_q;
   logic rx_valid_q;
   logic [7:0] rx_data_q;
   logic rx_error_q;
   // serial clock side
   logic [serial_front_pkg::LS_W-1:0] lsync_a_q;
   logic [serial_front_pkg::LS_W-1:0] lsync_b_q;
   logic [2:0] sck_cnt_q;
   logic [7:0] sck_rx_q;
   logic [7:0] sck_hold_q;
   logic sck_tgl_q;
   logic sck_ack_q;
   logic sck_tx_act_q;
   logic [7:0] sck_shift_q;
   logic sck_drive_low_q;
   // framer wires
   logic fr_tx_ready;
   logic fr_tx_line;
   logic fr_rx_valid;
   logic [7:0] fr_rx_data;
   logic fr_rx_error;
   // receive line idles high, so reset must not show a false start edge
   localparam logic [serial_front_pkg::MS_W-1:0] MSYNC_IDLE =
      serial_front_pkg::MS_W'(1) << serial_front_pkg::MS_RXD;

   wire [serial_front_pkg::MS_W-1:0] msync_in =
      {sck_ack_q, sck_tgl_q, rx_sck_pin, test_mode, sel};
   wire sel_m = msync_b_q[serial_front_pkg::MS_SEL];
   wire test_m = msync_b_q[serial_front_pkg::MS_TEST];
   wire rxd_m = msync_b_q[serial_front_pkg::MS_RXD];
   wire ack_m = msync_b_q[serial_front_pkg::MS_ACK];
   wire uart_m = (sel_m == serial_front_pkg::SEL_UART);
   wire sync_m = (sel_m == serial_front_pkg::SEL_SYNC);
   wire sync_rx_new = msync_b_q[serial_front_pkg::MS_RXTGL] ^ rx_tgl_seen_q;
   wire irq_evt = tunnel_cmd_event;
   wire fr_tx_valid = uart_m & ~test_m & (irq_pend_q | tx_valid);
   wire [7:0] fr_tx_data = irq_pend_q ? serial_front_pkg::IRQ_NOTIFY_CHAR : tx_data;
   wire fr_take = fr_tx_valid & fr_tx_ready;
   wire irq_sent = fr_take & irq_pend_q;
   wire sync_tx_free = (tx_req_q == ack_m);
   wire sync_take = sync_m & ~test_m & tx_valid & sync_tx_free;

   // user transmit handshake follows the selected port
   assign tx_ready = ~test_m & (uart_m ? (fr_tx_ready & ~irq_pend_q) : sync_tx_free);
   assign rx_valid = rx_valid_q;
   assign rx_data = rx_data_q;
   assign rx_error = rx_error_q;
   assign sync_mode = sync_m;

   // level and event crossings into the core clock
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         msync_a_q <= MSYNC_IDLE;
         msync_b_q <= MSYNC_IDLE;
      end else begin
         msync_a_q <= msync_in;
         msync_b_q <= msync_a_q;
      end
   end

   // bit timing fixed at the highest allowed uart rate
   uart_framer u_framer (
      .mclk(mclk),
      .rstn(rstn),
      .enable(uart_m),
      .rx_line(rxd_m),
      .tx_valid(fr_tx_valid),
      .tx_data(fr_tx_data),
      .tx_ready(fr_tx_ready),
      .tx_line(fr_tx_line),
      .rx_valid(fr_rx_valid),
      .rx_data(fr_rx_data),
      .rx_error(fr_rx_error)
   );

   // notify character pending; a new event wins over the clear
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         irq_pend_q <= 1'b0;
      end else begin
         irq_pend_q <= (irq_evt & uart_m) | (irq_pend_q & ~irq_sent & uart_m);
      end
   end

   // low pulse on the interrupt pins, restarted at full width by each event
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         irq_act_q <= 1'b0;
         irq_cnt_q <= 8'h00;
      end else if (irq_evt) begin
         irq_act_q <= 1'b1;
         irq_cnt_q <= serial_front_pkg::IRQ_PULSE_CNT;
      end else if (irq_cnt_q != 8'h00) begin
         irq_cnt_q <= irq_cnt_q - 8'h01;
      end else begin
         irq_act_q <= 1'b0;
      end
   end

   // synchronous transmit request toggles across to the serial clock
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tx_req_q <= 1'b0;
         tx_hold_q <= 8'h00;
      end else if (sync_take) begin
         tx_req_q <= ~tx_req_q;
         tx_hold_q <= tx_data;
      end
   end

   // received bytes from either port
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_tgl_seen_q <= 1'b0;
         rx_valid_q <= 1'b0;
         rx_data_q <= 8'h00;
         rx_error_q <= 1'b0;
      end else begin
         rx_tgl_seen_q <= msync_b_q[serial_front_pkg::MS_RXTGL];
         rx_valid_q <= uart_m ? fr_rx_valid : (sync_m & sync_rx_new);
         if (uart_m & fr_rx_valid) begin
            rx_data_q <= fr_rx_data;
            rx_error_q <= fr_rx_error;
         end else if (sync_m & sync_rx_new) begin
            rx_data_q <= sck_hold_q;
            rx_error_q <= 1'b0;
         end
      end
   end

   // serial clock domain: select, reset and request cross in here
   wire [serial_front_pkg::LS_W-1:0] lsync_in = {tx_req_q, rstn, sel};
   wire sel_l = (lsync_b_q[serial_front_pkg::LS_SEL] == serial_front_pkg::SEL_SYNC);
   wire rstn_l = lsync_b_q[serial_front_pkg::LS_RSTN];
   wire req_l = lsync_b_q[serial_front_pkg::LS_REQ];
   wire data_line = serial_out_low_volt_in & serial_out_high_volt_in;
   wire sck_first = (sck_cnt_q == serial_front_pkg::SYNC_FIRST_BIT);
   wire sck_last = (sck_cnt_q == serial_front_pkg::SYNC_LAST_BIT);
   wire sck_load = sck_first & (req_l != sck_ack_q);

   always_ff @(posedge rx_sck_pin) begin
      lsync_a_q <= lsync_in;
      lsync_b_q <= lsync_a_q;
   end

   // host clocks bits in on rising edges, lsb first
   always_ff @(posedge rx_sck_pin) begin
      if (!rstn_l) begin
         sck_cnt_q <= 3'h0;
         sck_rx_q <= 8'h00;
         sck_hold_q <= 8'h00;
         sck_tgl_q <= 1'b0;
      end else if (sel_l) begin
         sck_cnt_q <= sck_cnt_q + 3'h1;
         sck_rx_q <= {data_line, sck_rx_q[7:1]};
         if (sck_last & ~sck_tx_act_q) begin
            sck_hold_q <= {data_line, sck_rx_q[7:1]};
            sck_tgl_q <= ~sck_tgl_q;
         end
      end
   end

   // device drives the data line after each rising edge while sending
   always_ff @(posedge rx_sck_pin) begin
      if (!rstn_l) begin
         sck_ack_q <= 1'b0;
         sck_tx_act_q <= 1'b0;
         sck_shift_q <= 8'h00;
         sck_drive_low_q <= 1'b0;
      end else if (!sel_l) begin
         sck_tx_act_q <= 1'b0;
         sck_drive_low_q <= 1'b0;
      end else if (sck_first) begin
         sck_tx_act_q <= sck_load;
         sck_drive_low_q <= sck_load & ~tx_hold_q[0];
         if (sck_load) begin
            sck_ack_q <= req_l;
            sck_shift_q <= {1'b0, tx_hold_q[7:1]};
         end
      end else begin
         sck_drive_low_q <= sck_tx_act_q & ~sck_shift_q[0];
         sck_shift_q <= {1'b0, sck_shift_q[7:1]};
      end
   end

   // open-drain pins: only pull low or release
   wire tx_pull = ~test_m & (uart_m ? ~fr_tx_line : sck_drive_low_q);
   wire irq_pull = ~test_m & irq_act_q;
   assign serial_out_low_volt_out = 1'b0;
   assign serial_out_high_volt_out = 1'b0;
   assign host_interrupt_low_volt_out = 1'b0;
   assign host_interrupt_high_volt_out = 1'b0;
   assign serial_out_low_volt_oe_n = ~tx_pull;
   assign serial_out_high_volt_oe_n = ~tx_pull;
   assign host_interrupt_low_volt_oe_n = ~irq_pull;
   assign host_interrupt_high_volt_oe_n = ~irq_pull;
endmodule // host_serial_port_front_end

// >>> dv/host_serial_port_front_end_assertions.sv
// assertions for the host serial front end, watching its ports only
// assumes one core clock domain and a synchronous active-low reset
`timescale 1ns/10ps
module host_serial_port_front_end_assertions (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sel,
   input wire logic test_mode,
   input wire logic serial_out_low_volt_out,
   input wire logic serial_out_low_volt_oe_n,
   input wire logic serial_out_high_volt_out,
   input wire logic serial_out_high_volt_oe_n,
   input wire logic host_interrupt_low_volt_out,
   input wire logic host_interrupt_low_volt_oe_n,
   input wire logic host_interrupt_high_volt_out,
   input wire logic host_interrupt_high_volt_oe_n,
   input wire logic tunnel_cmd_event,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic sync_mode
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // length of the current low stretch on the interrupt pin
   logic [7:0] irq_low_q;
   always_ff @(posedge mclk) begin
      if (host_interrupt_low_volt_oe_n) irq_low_q <= 8'h00;
      else if (irq_low_q != 8'hFF) irq_low_q <= irq_low_q + 8'h01;
   end
   AST_PINS_NEVER_HIGH:
   assert property (!serial_out_low_volt_out && !serial_out_high_volt_out &&
      !host_interrupt_low_volt_out && !host_interrupt_high_volt_out) else $error("pin driven high");
   AST_TX_COPIES:
   assert property (serial_out_low_volt_oe_n == serial_out_high_volt_oe_n) else $error("tx copies differ");
   AST_IRQ_COPIES:
   assert property (host_interrupt_low_volt_oe_n == host_interrupt_high_volt_oe_n)
      else $error("irq copies differ");
   AST_MODE_FOLLOWS_SEL:
   assert property ($past(rstn) && $past(rstn, 2) |-> sync_mode == $past(sel, 2))
      else $error("mode does not follow select");
   AST_IRQ_AFTER_EVENT:
   assert property (tunnel_cmd_event && !test_mode && !$past(test_mode) && !$past(test_mode, 2)
      |=> !host_interrupt_low_volt_oe_n [*8]) else $error("no irq pulse after event");
   AST_IRQ_HAS_CAUSE:
   assert property ($fell(host_interrupt_low_volt_oe_n) |-> $past(tunnel_cmd_event))
      else $error("irq pulse without event");
   AST_IRQ_LENGTH:
   assert property ($rose(host_interrupt_low_volt_oe_n) && !test_mode && !$past(test_mode)
      && !$past(test_mode, 2) |-> irq_low_q > serial_front_pkg::IRQ_PULSE_CNT)
      else $error("irq pulse too short");
   AST_UART_START:
   assert property (tx_valid && tx_ready && !sync_mode |=> !serial_out_low_volt_oe_n [*8])
      else $error("no start bit");
   AST_UART_BUSY:
   assert property (tx_valid && tx_ready && !sync_mode |=> !tx_ready [*8])
      else $error("ready during frame");
   AST_NOTIFY_ON_TX:
   assert property (tunnel_cmd_event && tx_ready && !sync_mode && !test_mode
      |-> ##[1:4] !serial_out_low_volt_oe_n) else $error("no notify character");
endmodule // host_serial_port_front_end_assertions

// >>> dv/serial_host_model.sv
// host model: pull-ups, uart characters and the synchronous clock master
// assumes both data pin copies meet one host line
`timescale 1ns/10ps
module serial_host_model (
   output logic rx_sck_pin,
   input wire logic lv_oe_n,
   input wire logic hv_oe_n,
   output wire logic line_lv,
   output wire logic line_hv
);
   localparam real BIT_NS = 1.0e9 / 38400.0;
   localparam real HALF_NS = 15.0;
   logic drive_n = 1'b1;
   initial rx_sck_pin = 1'b1;
   // a released line reads high through the pull-up
   assign line_lv = lv_oe_n & drive_n;
   assign line_hv = hv_oe_n & drive_n;
   task automatic idle(input logic lvl);
      rx_sck_pin = lvl;
   endtask
   // start, data lsb first, even parity, stop
   task automatic uart_send(input logic [7:0] d, input logic bad);
      logic [10:0] f;
      f = {1'b1, ^d ^ bad, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rx_sck_pin = f[i];
         #(BIT_NS);
      end
   endtask
   task automatic uart_recv(output logic [10:0] f);
      wait (line_lv === 1'b0);
      #(BIT_NS / 2.0);
      for (int i = 0; i < 11; i++) begin
         f[i] = line_lv;
         if (i < 10) #(BIT_NS);
      end
   endtask
   // host is master and clocks each frame, clock low between frames
   task automatic sck_edges(input int n);
      #3.7;
      repeat (n) begin
         #(HALF_NS) rx_sck_pin = 1'b1;
         #(HALF_NS) rx_sck_pin = 1'b0;
      end
   endtask
   task automatic sync_frame(input logic [7:0] d, output logic [7:0] q);
      #3.7;
      for (int i = 0; i < 8; i++) begin
         drive_n = d[i];
         #(HALF_NS) rx_sck_pin = 1'b1;
         #(HALF_NS) q[i] = line_lv & line_hv;
         rx_sck_pin = 1'b0;
      end
      drive_n = 1'b1;
   endtask
endmodule // serial_host_model

// >>> dv/host_serial_port_front_end_bench.sv
// self-checking bench for the host serial front end with a host model
// assumes the package, design, checker and host model are compiled first
`timescale 1ns/10ps
module host_serial_port_front_end_bench;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic sel = 1'b0;
   logic test_mode = 1'b0;
   logic tunnel_cmd_event = 1'b0;
   logic tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   wire rx_sck_pin, line_lv, line_hv;
   logic lv_oe_n, hv_oe_n, ilv_oe_n, tx_ready, rx_valid, rx_error, sync_mode;
   logic [7:0] rx_data;
   logic [31:0] seed = 32'h1E58;
   int fail_count = 0;
   int tests_run = 0;
   int irq_low = 0;
   logic [8:0] rxq[$];
   host_serial_port_front_end uut (.mclk(mclk), .rstn(rstn), .sel(sel), .test_mode(test_mode),
      .rx_sck_pin(rx_sck_pin), .serial_out_low_volt_in(line_lv), .serial_out_low_volt_out(),
      .serial_out_low_volt_oe_n(lv_oe_n), .serial_out_high_volt_in(line_hv),
      .serial_out_high_volt_out(), .serial_out_high_volt_oe_n(hv_oe_n),
      .host_interrupt_low_volt_out(), .host_interrupt_low_volt_oe_n(ilv_oe_n),
      .host_interrupt_high_volt_out(), .host_interrupt_high_volt_oe_n(),
      .tunnel_cmd_event(tunnel_cmd_event), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
      .sync_mode(sync_mode));
   serial_host_model host (.rx_sck_pin(rx_sck_pin), .lv_oe_n(lv_oe_n), .hv_oe_n(hv_oe_n),
      .line_lv(line_lv), .line_hv(line_hv));
   always #5 mclk = ~mclk;
   always @(negedge mclk) begin
      if (ilv_oe_n === 1'b0) irq_low++;
      if (rx_valid === 1'b1) rxq.push_back({rx_error, rx_data});
   end
   function automatic logic [10:0] frame(input logic [7:0] d);
      return {1'b1, ^d, d, 1'b0};
   endfunction
   function automatic logic [7:0] rnd8();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic fire();
      @(posedge mclk);
      tunnel_cmd_event <= 1'b1;
      @(posedge mclk);
      tunnel_cmd_event <= 1'b0;
   endtask
   task automatic send(input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      tx_valid <= 1'b1;
      tx_data <= d;
      do begin
         @(negedge mclk);
         n++;
      end while (tx_ready !== 1'b1 && n < 70000);
      @(posedge mclk);
      tx_valid <= 1'b0;
   endtask
   // link flops see reset only while the serial clock runs
   task automatic do_reset(input logic s);
      @(posedge mclk);
      rstn <= 1'b0;
      sel <= s;
      host.idle(~s);
      fork
         cyc(5);
         host.sck_edges(4 * s);
      join
      @(posedge mclk);
      rstn <= 1'b1;
      cyc(3);
      host.sck_edges(2 * s);
   endtask
   initial begin
      logic [7:0] b;
      logic [7:0] q;
      logic [7:0] got;
      logic [7:0] v[3];
      logic [10:0] f;
      int single;
      do_reset(1'b0);
      check("uart mode", sync_mode, 0);
      b = rnd8();
      v[1] = rnd8();
      v[2] = rnd8();
      irq_low = 0;
      fork
         begin
            fire();
            cyc(200);
            check("irq pulse", irq_low >= serial_front_pkg::IRQ_PULSE_CYC &&
               irq_low <= serial_front_pkg::IRQ_PULSE_CYC + 1, 1);
            send(b);
         end
         begin
            host.uart_recv(f);
            check("notify char", f, frame(serial_front_pkg::IRQ_NOTIFY_CHAR));
            host.uart_recv(f);
            check("uart tx char", f, frame(b));
         end
         begin
            host.uart_send(v[1], 1'b0);
            host.uart_send(v[2], 1'b1);
         end
      join
      cyc(20);
      check("uart rx count", rxq.size(), 2);
      check("uart rx good", rxq[0], {1'b0, v[1]});
      check("uart rx bad parity", rxq[1], {1'b1, v[2]});
      $display("uart test done");
      do_reset(1'b1);
      check("sync mode", sync_mode, 1);
      irq_low = 0;
      fire();
      cyc(200);
      single = irq_low;
      irq_low = 0;
      fire();
      cyc(39);
      fire();
      cyc(300);
      check("irq retrigger", irq_low - single, 41);
      test_mode <= 1'b1;
      cyc(3);
      irq_low = 0;
      fire();
      cyc(200);
      check("irq in test", irq_low, 0);
      test_mode <= 1'b0;
      cyc(10);
      $display("irq test done");
      v[0] = 8'h00;
      rxq.delete();
      for (int i = 0; i < 3; i++) host.sync_frame(v[i], q);
      cyc(10);
      for (int i = 0; i < 3; i++) check("sync rx byte", rxq[i], {1'b0, v[i]});
      b = rnd8();
      b[0] = 1'b0;
      got = 8'hFF;
      fork
         send(b);
         for (int k = 0; k < 5; k++) begin
            host.sync_frame(8'hFF, q);
            if (q !== 8'hFF) got = q;
         end
      join
      check("sync tx byte", got, b);
      $display("sync test done");
      complete_run();
   end
   initial begin
      repeat (90000) @(posedge mclk);
      fail_count++;
      $display("watchdog expired");
      complete_run();
   end
endmodule // host_serial_port_front_end_bench
bind host_serial_port_front_end host_serial_port_front_end_assertions chk (.mclk, .rstn, .sel,
   .test_mode, .serial_out_low_volt_out, .serial_out_low_volt_oe_n, .serial_out_high_volt_out,
   .serial_out_high_volt_oe_n, .host_interrupt_low_volt_out, .host_interrupt_low_volt_oe_n,
   .host_interrupt_high_volt_out, .host_interrupt_high_volt_oe_n, .tunnel_cmd_event,
   .tx_valid, .tx_ready, .sync_mode);
